/* File: design/mfc_pkg.sv */
// constants and register layout for the mac interface and fast ethernet config bank
// Overview of operation
// - control register bits 15:8 ignore writes and read as zero.
// - control bit 7 enables the parallel mac interface; reset is 1 or strap.
// - control bits 6:5, reset 10, set the receive fifo midlevel threshold.
// - control bits 4:3, reset 10, set the transmit fifo midlevel threshold.
// - control bit 1, reset 1, shifts transmit clock against data; 0 aligns.
// - control bit 0, reset 1, shifts receive clock against data; 0 aligns.
// - second control bit 4, reset 0, routes the path around the async fifo.
// - second control bit 3, reset 0, skips the receive clock lag at 10/100.
// - second control bit 2, reset 0, selects low latency 10/100 datapath.
// - status bit 1 reads 1 once a serial page arrived; resets to 0.
// - status bit 0 reads 1 when serial negotiation is done; resets to 0.
// - config bit 11 at 0 stops reception of packets over 1.5 ms.
// - config bits 10:7, reset 1111, set recovery time after unlock in ms.
// - config bit 6, reset 0, forces a good 100 Mb/s link indication.
// - config bit 5, reset 1, enables improved ternary detection.
// - config bit 4, reset 0, enables improved inter-packet gap detection.
// - config bit 2, reset 0, turns off the transmit scrambler.
// - config bit 1, reset 0, flags reception of an odd nibble count.
// - config bit 0, reset 0, asserts receive valid early toward the mac.
package mfc_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CTL = 8'h32;
  localparam logic [7:0] IDX_CTL2 = 8'h33;
  localparam logic [7:0] IDX_NEG_STS = 8'h37;
  localparam logic [7:0] IDX_FE_CFG = 8'h43;
  // control register fields
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_RXTHR_LO = 5;
  localparam int CTL_TXTHR_LO = 3;
  localparam int CTL_TXDLY_BIT = 1;
  localparam int CTL_RXDLY_BIT = 0;
  localparam logic [7:0] CTL_RW_MASK = 8'hfb;
  localparam logic [7:0] CTL_RESET = 8'hd3;
  // second control register fields
  localparam int CTL2_SKIP_BIT = 4;
  localparam int CTL2_LAG_BIT = 3;
  localparam int CTL2_LOWLAT_BIT = 2;
  localparam logic [4:0] CTL2_RESET = 5'h00;
  // fast ethernet config fields
  localparam int FE_WD_OFF_BIT = 11;
  localparam int FE_REC_LO = 7;
  localparam int FE_FORCE_BIT = 6;
  localparam int FE_TERN_BIT = 5;
  localparam int FE_GAP_BIT = 4;
  localparam int FE_WHITE_BIT = 2;
  localparam int FE_ODD_BIT = 1;
  localparam int FE_EARLY_BIT = 0;
  localparam logic [11:0] FE_RW_MASK = 12'hff7;
  localparam logic [11:0] FE_RESET = 12'h7a0;
  // status fields
  localparam int STS_PAGE_BIT = 1;
  localparam int STS_DONE_BIT = 0;
  // timing
  localparam int CLK_FREQ_MHZ = 50;
  localparam int WATCHDOG_US = 1500;
  localparam int US_PER_MS = 1000;
  localparam int WATCHDOG_CYC = WATCHDOG_US * CLK_FREQ_MHZ;
  localparam int MS_CYC = US_PER_MS * CLK_FREQ_MHZ;
  localparam int STRAP_SETTLE = 3;
endpackage

/* File: design/mfc_regs.sv */
// apb register bank for the mac interface and 100 Mb/s receive path settings
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mfc_regs #(
  parameter int ADDR_W = 12,
  parameter int FIFO_DEPTH = 16,
  parameter int LVL_W = 5,
  parameter bit EN_FROM_STRAP = 1'b0,
  parameter int WATCHDOG_CYCLES = mfc_pkg::WATCHDOG_CYC,
  parameter int MS_CYCLES = mfc_pkg::MS_CYC
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic EN_STRAP_IN,
  input wire logic SERIAL_PAGE_RX_IN,
  input wire logic SERIAL_NEG_DONE_IN,
  input wire logic LINK_CLK_IN,
  input wire logic RX_DV_IN,
  input wire logic LINK_DETECT_IN,
  input wire logic DESCR_LOCK_IN,
  output logic PARALLEL_IF_EN_OUT,
  output logic [LVL_W-1:0] RX_FIFO_LEVEL_OUT,
  output logic [LVL_W-1:0] TX_FIFO_LEVEL_OUT,
  output logic TX_CLK_SHIFT_OUT,
  output logic RX_CLK_SHIFT_OUT,
  output logic ASYNC_FIFO_SKIP_OUT,
  output logic SKIP_CLOCK_LAG_OUT,
  output logic LOW_LATENCY_OUT,
  output logic LINK_100_GOOD_OUT,
  output logic IMPROVED_TERNARY_OUT,
  output logic IMPROVED_GAP_OUT,
  output logic TX_WHITENING_OFF_OUT,
  output logic RX_ABORT_OUT,
  output logic RECOVERING_OUT,
  output logic ODD_NIBBLE_OUT,
  output logic RX_VALID_OUT
);
  import mfc_pkg::*;

  typedef enum logic [1:0] {
    SEL_CTL = 2'b00,
    SEL_CTL2 = 2'b01,
    SEL_STS = 2'b10,
    SEL_FE = 2'b11
  } mfc_sel_e;

  // address decode, shared by read and write paths
  function automatic logic decode_hit(input logic [ADDR_W-1:0] a, output mfc_sel_e s);
    decode_hit = 1'b1;
    s = SEL_CTL;
    case (a)
      ADDR_W'({IDX_CTL, 2'b00}): s = SEL_CTL;
      ADDR_W'({IDX_CTL2, 2'b00}): s = SEL_CTL2;
      ADDR_W'({IDX_NEG_STS, 2'b00}): s = SEL_STS;
      ADDR_W'({IDX_FE_CFG, 2'b00}): s = SEL_FE;
      default: decode_hit = 1'b0;
    endcase
  endfunction

  // threshold code to fill level: 00,01,10,11 give 2/8..5/8 of depth
  function automatic logic [LVL_W-1:0] thr_level(input logic [1:0] code);
    thr_level = LVL_W'(((int'(code) + 2) * FIFO_DEPTH) / 8);
  endfunction

  logic [7:0] ctl;
  logic [4:0] ctl2;
  logic [11:0] fe;
  mfc_sel_e sel;
  logic hit;
  logic wr_en;
  logic rd_setup;
  logic [1:0] sync_page;
  logic [1:0] sync_done;
  logic [2:0] sync_lclk;
  logic [2:0] sync_dv;
  logic [1:0] sync_det;
  logic [2:0] sync_lock;
  logic [1:0] sync_strap;
  logic [1:0] strap_cnt;
  logic dv_late;
  logic nib_odd;
  logic [31:0] frame_cnt;
  logic rx_abort;
  logic [31:0] ms_cnt;
  logic [3:0] rec_cnt;
  logic rx_valid;
  logic odd_pulse;
  logic dv_s;
  logic lclk_rise;
  logic dv_fall;
  logic lock_fall;

  // decode happens combinationally; registers answer with no wait states
  always_comb begin
    hit = decode_hit(PADDR_IN, sel);
  end
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && hit;
  assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;

  // two-stage synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync_page <= 2'h0;
      sync_done <= 2'h0;
      sync_lclk <= 3'h0;
      sync_dv <= 3'h0;
      sync_det <= 2'h0;
      sync_lock <= 3'h0;
      sync_strap <= 2'h0;
    end else begin
      sync_page <= {sync_page[0], SERIAL_PAGE_RX_IN};
      sync_done <= {sync_done[0], SERIAL_NEG_DONE_IN};
      sync_lclk <= {sync_lclk[1:0], LINK_CLK_IN};
      sync_dv <= {sync_dv[1:0], RX_DV_IN};
      sync_det <= {sync_det[0], LINK_DETECT_IN};
      sync_lock <= {sync_lock[1:0], DESCR_LOCK_IN};
      sync_strap <= {sync_strap[0], EN_STRAP_IN};
    end
  end
  assign dv_s = sync_dv[1];
  assign lclk_rise = sync_lclk[1] && !sync_lclk[2];
  assign dv_fall = !sync_dv[1] && sync_dv[2];
  assign lock_fall = !sync_lock[1] && sync_lock[2];

  // strap capture waits for the synchroniser to fill after reset release
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != 2'(STRAP_SETTLE)) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  // control register: reserved bits never stored
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctl <= CTL_RESET;
    end else if (wr_en && sel == SEL_CTL) begin
      ctl <= PWDATA_IN[7:0] & CTL_RW_MASK;
    end else if (EN_FROM_STRAP && strap_cnt == 2'(STRAP_SETTLE - 1)) begin
      ctl[CTL_EN_BIT] <= sync_strap[1];
    end
  end

  // second control register
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctl2 <= CTL2_RESET;
    end else if (wr_en && sel == SEL_CTL2) begin
      ctl2 <= {PWDATA_IN[4:2], 2'b00};
    end
  end

  // fast ethernet configuration register
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      fe <= FE_RESET;
    end else if (wr_en && sel == SEL_FE) begin
      fe <= PWDATA_IN[11:0] & FE_RW_MASK;
    end
  end

  // read data is loaded in the setup cycle so it is a flop in the access cycle
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PRDATA_OUT <= 32'h0;
    end else if (rd_setup) begin
      PRDATA_OUT <= 32'h0;
      if (hit) begin
        case (sel)
          SEL_CTL: PRDATA_OUT <= {24'h0, ctl};
          SEL_CTL2: PRDATA_OUT <= {27'h0, ctl2};
          SEL_STS: PRDATA_OUT <= {30'h0, sync_page[1], sync_done[1]};
          SEL_FE: PRDATA_OUT <= {20'h0, fe};
          default: PRDATA_OUT <= 32'h0;
        endcase
      end
    end
  end

  // settings toward the datapath
  assign PARALLEL_IF_EN_OUT = ctl[CTL_EN_BIT];
  assign RX_FIFO_LEVEL_OUT = thr_level(ctl[CTL_RXTHR_LO +: 2]);
  assign TX_FIFO_LEVEL_OUT = thr_level(ctl[CTL_TXTHR_LO +: 2]);
  assign TX_CLK_SHIFT_OUT = ctl[CTL_TXDLY_BIT];
  assign RX_CLK_SHIFT_OUT = ctl[CTL_RXDLY_BIT];
  assign ASYNC_FIFO_SKIP_OUT = ctl2[CTL2_SKIP_BIT];
  assign SKIP_CLOCK_LAG_OUT = ctl2[CTL2_LAG_BIT];
  assign LOW_LATENCY_OUT = ctl2[CTL2_LOWLAT_BIT];
  assign LINK_100_GOOD_OUT = fe[FE_FORCE_BIT] || sync_det[1];
  assign IMPROVED_TERNARY_OUT = fe[FE_TERN_BIT];
  assign IMPROVED_GAP_OUT = fe[FE_GAP_BIT];
  assign TX_WHITENING_OFF_OUT = fe[FE_WHITE_BIT];
  assign RX_ABORT_OUT = rx_abort;
  assign RECOVERING_OUT = rec_cnt != 4'h0;
  assign ODD_NIBBLE_OUT = odd_pulse;
  assign RX_VALID_OUT = rx_valid;

  // packet-length watchdog; abort holds until the frame ends
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      frame_cnt <= 32'h0;
      rx_abort <= 1'b0;
    end else if (!dv_s) begin
      frame_cnt <= 32'h0;
      rx_abort <= 1'b0;
    end else begin
      if (frame_cnt != 32'(WATCHDOG_CYCLES)) begin
        frame_cnt <= frame_cnt + 32'h1;
      end
      if (frame_cnt == 32'(WATCHDOG_CYCLES - 1) && !fe[FE_WD_OFF_BIT]) begin
        rx_abort <= 1'b1;
      end
    end
  end

  // recovery after the descrambler loses lock, counted in whole ms
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ms_cnt <= 32'h0;
      rec_cnt <= 4'h0;
    end else if (lock_fall) begin
      ms_cnt <= 32'h0;
      rec_cnt <= fe[FE_REC_LO +: 4];
    end else if (rec_cnt != 4'h0) begin
      if (ms_cnt == 32'(MS_CYCLES - 1)) begin
        ms_cnt <= 32'h0;
        rec_cnt <= rec_cnt - 4'h1;
      end else begin
        ms_cnt <= ms_cnt + 32'h1;
      end
    end
  end

  // nibble parity counted on sampled link clock edges; checked at frame end
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      nib_odd <= 1'b0;
      odd_pulse <= 1'b0;
    end else begin
      odd_pulse <= dv_fall && nib_odd && fe[FE_ODD_BIT];
      if (dv_fall) begin
        nib_odd <= 1'b0;
      end else if (lclk_rise && dv_s) begin
        nib_odd <= !nib_odd;
      end
    end
  end

  // early valid skips one pipeline stage; abort masks valid
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      dv_late <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      dv_late <= dv_s;
      rx_valid <= (fe[FE_EARLY_BIT] ? dv_s : dv_late) && !rx_abort;
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_rd_ctl;
    rd_setup && hit && sel == SEL_CTL;
  endsequence
  property p_ctl_reserved_zero;
    s_rd_ctl |=> PRDATA_OUT[31:8] == 24'h0;
  endproperty
  a_ctl_reserved_zero: assert property (p_ctl_reserved_zero)
    else $error("reserved control bits read nonzero");

  property p_if_enable;
    (wr_en && sel == SEL_CTL) |=> PARALLEL_IF_EN_OUT == $past(PWDATA_IN[7]);
  endproperty
  a_if_enable: assert property (p_if_enable)
    else $error("interface enable did not follow write");

  property p_rx_level;
    (wr_en && sel == SEL_CTL && PWDATA_IN[6:5] == 2'b10) |=>
      RX_FIFO_LEVEL_OUT == LVL_W'(FIFO_DEPTH / 2);
  endproperty
  a_rx_level: assert property (p_rx_level)
    else $error("default receive threshold code not midpoint");

  property p_tx_shift;
    (wr_en && sel == SEL_CTL) |=> TX_CLK_SHIFT_OUT == $past(PWDATA_IN[1]);
  endproperty
  a_tx_shift: assert property (p_tx_shift)
    else $error("transmit clock shift did not follow write");

  property p_tx_level;
    (wr_en && sel == SEL_CTL && PWDATA_IN[4:3] == 2'b10) |=>
      TX_FIFO_LEVEL_OUT == LVL_W'(FIFO_DEPTH / 2);
  endproperty
  a_tx_level: assert property (p_tx_level)
    else $error("default transmit threshold code not midpoint");

  property p_rx_shift;
    (wr_en && sel == SEL_CTL) |=> RX_CLK_SHIFT_OUT == $past(PWDATA_IN[0]);
  endproperty
  a_rx_shift: assert property (p_rx_shift)
    else $error("receive clock shift did not follow write");

  // the second control bits drive the datapath straight from the register
  property p_ctl2_bits;
    (wr_en && sel == SEL_CTL2) |=>
      {ASYNC_FIFO_SKIP_OUT, SKIP_CLOCK_LAG_OUT, LOW_LATENCY_OUT} == $past(PWDATA_IN[4:2]);
  endproperty
  a_ctl2_bits: assert property (p_ctl2_bits)
    else $error("second control settings did not follow write");

  property p_fe_bits;
    (wr_en && sel == SEL_FE) |=>
      {IMPROVED_TERNARY_OUT, IMPROVED_GAP_OUT, TX_WHITENING_OFF_OUT} ==
        $past({PWDATA_IN[5:4], PWDATA_IN[2]});
  endproperty
  a_fe_bits: assert property (p_fe_bits)
    else $error("receive path settings did not follow write");

  property p_status_read;
    rd_setup && hit && sel == SEL_STS |=>
      PRDATA_OUT[1:0] == $past({sync_page[1], sync_done[1]}) && PRDATA_OUT[31:2] == 30'h0;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("negotiation status read wrong");

  property p_watchdog;
    (dv_s && frame_cnt == 32'(WATCHDOG_CYCLES - 1) && !fe[FE_WD_OFF_BIT]) |=>
      rx_abort ##1 !RX_VALID_OUT;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("long packet not stopped");

  property p_recovery;
    (lock_fall && fe[FE_REC_LO +: 4] != 4'h0) |=> RECOVERING_OUT [*8];
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("recovery time not started");

  property p_force_link;
    fe[FE_FORCE_BIT] |-> LINK_100_GOOD_OUT;
  endproperty
  a_force_link: assert property (p_force_link)
    else $error("forced link not good");

  property p_odd_nibble;
    (dv_fall && nib_odd && fe[FE_ODD_BIT]) |=> ODD_NIBBLE_OUT ##1 !ODD_NIBBLE_OUT;
  endproperty
  a_odd_nibble: assert property (p_odd_nibble)
    else $error("odd nibble count not flagged");

  sequence s_dv_rise_early;
    $rose(dv_s) && fe[FE_EARLY_BIT] && !rx_abort;
  endsequence
  sequence s_dv_rise_late;
    $rose(dv_s) && !fe[FE_EARLY_BIT] && !rx_abort;
  endsequence
  property p_early_valid;
    s_dv_rise_early |=> RX_VALID_OUT;
  endproperty
  a_early_valid: assert property (p_early_valid)
    else $error("early valid not one cycle after data valid");
  property p_late_valid;
    s_dv_rise_late ##1 dv_s |=> !$past(RX_VALID_OUT) && RX_VALID_OUT;
  endproperty
  a_late_valid: assert property (p_late_valid)
    else $error("normal valid not two cycles after data valid");

endmodule // mfc_regs
`default_nettype wire

/* File: verif/mfc_link_model.sv */
// link-side partner: nibble clock and receive valid coming off the line
`timescale 1ns/1ps
`default_nettype none
module mfc_link_model (
  input wire logic clk_in,
  output var logic link_clk_out,
  output var logic rx_dv_out
);
  // the nibble clock stands still between frames, so nothing counts outside one
  initial begin
    link_clk_out = 1'h0;
    rx_dv_out = 1'h0;
  end
  // valid rises just after a system edge so its latency can be measured
  task automatic start();
    @(posedge clk_in);
    rx_dv_out <= 1'h1;
  endtask
  // one 160 ns link clock period per nibble; edges land just after a system
  // edge so the sampled nibble count and frame length never race the clock
  task automatic nib(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_in);
      link_clk_out <= 1'h1;
      repeat (4) @(posedge clk_in);
      link_clk_out <= 1'h0;
    end
  endtask
  // drop valid and stay quiet long enough to keep frames apart
  task automatic stop();
    @(posedge clk_in);
    rx_dv_out <= 1'h0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // mfc_link_model
`default_nettype wire

/* File: verif/tb_mfc_regs.sv */
// self-checking bench for the register bank and its receive path
`timescale 1ns/1ps
`default_nettype none
module tb_mfc_regs;
  import mfc_pkg::*;
  localparam int WD = 40;
  localparam int MSC = 10;
  localparam logic [11:0] A_CTL = {2'h0, IDX_CTL, 2'h0};
  localparam logic [11:0] A_CTL2 = {2'h0, IDX_CTL2, 2'h0};
  localparam logic [11:0] A_STS = {2'h0, IDX_NEG_STS, 2'h0};
  localparam logic [11:0] A_FE = {2'h0, IDX_FE_CFG, 2'h0};
  logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v, seed = 32'h143bd;
  logic pready, pslverr, page = 1'h0, done = 1'h0, det = 1'h0, lock = 1'h1;
  logic lclk, dv, en, tsh, rsh, skip, lag, lowl, good, tern, gap, woff, abrt, recov, odd, valid;
  logic [4:0] rxl, txl;
  logic [33:0] n;
  logic [33:0] notes[$];
  int fail_count = 0, total_checks = 0, odd_seen = 0;
  // link cases: config, nibbles, valid latency, odd pulses, {abort, valid}
  logic [31:0] cfg[5] = '{32'h7a3, 32'h7a0, 32'h7a2, 32'h7a0, 32'hfa0};
  int nb[5] = '{3, 3, 4, 8, 8};
  int lat[5] = '{4, 5, 5, 5, 5};
  int od[5] = '{1, 0, 0, 0, 0};
  logic [1:0] ab[5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h1};
  always #10 clk = ~clk;
  mfc_regs #(.WATCHDOG_CYCLES(WD), .MS_CYCLES(MSC)) u_dut (.SYS_CLK_IN(clk), .RESETN_IN(rstn),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EN_STRAP_IN(1'h0),
    .SERIAL_PAGE_RX_IN(page), .SERIAL_NEG_DONE_IN(done), .LINK_CLK_IN(lclk), .RX_DV_IN(dv),
    .LINK_DETECT_IN(det), .DESCR_LOCK_IN(lock), .PARALLEL_IF_EN_OUT(en),
    .RX_FIFO_LEVEL_OUT(rxl), .TX_FIFO_LEVEL_OUT(txl), .TX_CLK_SHIFT_OUT(tsh),
    .RX_CLK_SHIFT_OUT(rsh), .ASYNC_FIFO_SKIP_OUT(skip), .SKIP_CLOCK_LAG_OUT(lag),
    .LOW_LATENCY_OUT(lowl), .LINK_100_GOOD_OUT(good), .IMPROVED_TERNARY_OUT(tern),
    .IMPROVED_GAP_OUT(gap), .TX_WHITENING_OFF_OUT(woff), .RX_ABORT_OUT(abrt),
    .RECOVERING_OUT(recov), .ODD_NIBBLE_OUT(odd), .RX_VALID_OUT(valid));
  mfc_link_model u_link (.clk_in(clk), .link_clk_out(lclk), .rx_dv_out(dv));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one apb transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    int k;
    notes.push_back({wr, err, exp});
    psel <= 1'h1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    if (k >= 16) begin
      fail_count++;
      complete_run();
    end
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  // each completed access takes the oldest note; read data only for reads
  always @(posedge clk) begin
    odd_seen <= odd_seen + int'(odd === 1'h1);
    if (psel && pen && pready === 1'h1) begin
      n = notes.pop_front();
      if (!n[33]) chk(prdata, n[31:0]);
      chk(pslverr, n[32]);
    end
  end
  // a hang is cut short here and counted
  initial begin
    #1000000;
    fail_count++;
    complete_run();
  end
  initial begin
    int c, k;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    apb(1'h0, A_CTL, 0, 32'hd3, 1'h0);
    apb(1'h0, A_CTL2, 0, 0, 1'h0);
    apb(1'h0, A_STS, 0, 0, 1'h0);
    apb(1'h0, A_FE, 0, 32'h7a0, 1'h0);
    chk({en, tsh, rsh, tern, rxl, txl}, {4'hf, 5'h8, 5'h8});
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      v[6:5] = i[1:0];
      v[4:3] = ~i[1:0];
      apb(1'h1, A_CTL, v, 0, 1'h0);
      apb(1'h0, A_CTL, 0, v & 32'hfb, 1'h0);
      chk({en, tsh, rsh, rxl, txl}, {v[7], v[1], v[0], {2'h0, v[6:5], 1'h0} + 5'h4,
          {2'h0, v[4:3], 1'h0} + 5'h4});
      apb(1'h1, A_CTL2, v, 0, 1'h0);
      apb(1'h0, A_CTL2, 0, v & 32'h1c, 1'h0);
      chk({skip, lag, lowl}, v[4:2]);
      apb(1'h1, A_FE, v, 0, 1'h0);
      apb(1'h0, A_FE, 0, v & 32'hff7, 1'h0);
      chk({good, tern, gap, woff}, {v[6:4], v[2]});
      apb(1'h1, A_STS, v, 0, 1'h0);
      apb(1'h0, A_STS, 0, 0, 1'h0);
    end
    apb(1'h0, 12'h000, 0, 0, 1'h1);
    apb(1'h1, 12'hffc, v, 0, 1'h1);
    apb(1'h0, A_CTL + 12'h1, 0, 0, 1'h1);
    $display("register access done");
    for (int i = 1; i < 4; i++) begin
      {page, done} <= i[1:0];
      repeat (4) @(posedge clk);
      apb(1'h0, A_STS, 0, i, 1'h0);
    end
    apb(1'h1, A_FE, 32'h7a0, 0, 1'h0);
    det <= 1'h1;
    repeat (4) @(posedge clk);
    chk(good, 1'h1);
    det <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, A_FE, cfg[i], 0, 1'h0);
      c = odd_seen;
      u_link.start();
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (valid !== 1'h1 && k < 10);
      chk(k, lat[i]);
      u_link.nib(nb[i]);
      chk({abrt, valid}, ab[i]);
      u_link.stop();
      repeat (6) @(posedge clk);
      chk(odd_seen - c, od[i]);
    end
    $display("link frames done");
    apb(1'h1, A_FE, 32'h1a0, 0, 1'h0);
    lock <= 1'h0;
    k = 0;
    while (recov !== 1'h1 && k < 10) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    while (recov === 1'h1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    chk(k, 3 * MSC);
    lock <= 1'h1;
    $display("recovery done");
    complete_run();
  end
endmodule // tb_mfc_regs
`default_nettype wire
